/* File: hw/irq_ctl_pkg.sv */
package irq_ctl_pkg;
  // ****************************************************************
  // register map (one address per register, bytes)
  // ****************************************************************
  localparam logic [3:0] ADDR_EDGE_SEL = 4'h2;
  localparam logic [3:0] ADDR_EN_ONE = 4'h3;
  localparam logic [3:0] ADDR_EN_TWO = 4'h4;
  localparam logic [3:0] ADDR_REQ_ONE = 4'h6;
  localparam logic [3:0] ADDR_PENDING = 4'h8;
  // ****************************************************************
  // reset values and fixed bits
  // ****************************************************************
  localparam logic [7:0] EDGE_SEL_RESET = 8'hE0;
  localparam logic [7:0] EDGE_SEL_FIXED = 8'hE0;
  localparam logic [7:0] EN_RESET = 8'h00;
  localparam logic [7:0] REQ_ONE_RESET = 8'h20;
  localparam logic [7:0] REQ_ONE_FIXED = 8'h20;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BIT_TIMER_A = 7;
  localparam int BIT_SERIAL_ONE = 6;
  localparam int BIT_WAKEUP = 5;
  localparam int BIT_DIRECT_XFER = 7;
  localparam int BIT_CONV_END = 6;
  localparam int BIT_SERIAL_TWO = 5;
  localparam int BIT_TIMER_G = 4;
  localparam int BIT_TIMER_F_HIGH = 3;
  localparam int BIT_TIMER_F_LOW = 2;
  localparam int BIT_TIMER_C = 1;
  localparam int BIT_TIMER_B = 0;
  localparam int NUM_EXT_PINS = 5;
endpackage : irq_ctl_pkg

/* File: hw/pin_edge_detect.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and selection
  input wire logic pin,
  input wire logic rising_sel,
  // result
  output logic edge_seen
);
  typedef struct packed
  {
    logic prev_r;
  } edge_state_t;

  edge_state_t st_r;
  edge_state_t st_nxt;

  // prev starts high so a high pin after reset is not taken as a rising edge
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.prev_r = pin;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{prev_r: 1'b1};
    else
      st_r <= st_nxt;
  end

  // 0 selects falling, 1 selects rising
  assign edge_seen = rising_sel ? (pin & ~st_r.prev_r) : (~pin & st_r.prev_r);
endmodule : pin_edge_detect
`default_nettype wire

/* File: hw/irq_enable_flag_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - edge bits 3..0 select falling edge when 0 (reset), rising when 1.
// - enable register one is eight bits, read/write, resets to zero.
// - enable one bit 7 gates timer A overflow requests.
// - enable one bit 6 gates serial channel one completion requests.
// - enable one bit 5 gates all eight wakeup pin requests together.
// - enable one bits 4..0 gate external pins 4..0 individually.
// - enable two bit 7 gates the direct transfer request.
// - enable two bit 6 gates conversion-end requests.
// - enable two bit 5 gates serial two complete and abort requests.
// - enable two bit 4 gates timer G capture and overflow requests.
// - enable two bit 3 gates timer F upper half requests.
// - enable two bit 2 gates timer F lower half requests.
// - enable two bit 1 gates timer C overflow and underflow requests.
// - enable two bit 0 gates timer B requests.
// - request flags stay set on acceptance; only software clears them.
// - writing zero clears a flag; writing one leaves it unchanged.
// - request bit 7 sets on timer A counter wrap FF to 00.
// - request bit 6 sets when a serial channel one transfer completes.
// - request bit 5 is reserved, reads one, ignores writes.
// - request bits 4..0 set on selected edge of interrupt-configured pin n.
// - global mask blocks acceptance but flags still set.
// - edge bit 4 selects falling when 0 (reset), rising when 1.
// - edge register bits 7..5 reserved, read one, ignore writes.
module irq_enable_flag_control
  import irq_ctl_pkg::*;
#(
  parameter int EXT_PINS = NUM_EXT_PINS
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // external request pins and their function select
  input wire logic [EXT_PINS-1:0] ext_pin,
  input wire logic [EXT_PINS-1:0] ext_pin_is_irq,
  // peripheral event strobes and flags held elsewhere
  input wire logic timer_a_overflow,
  input wire logic serial_one_done,
  input wire logic [7:0] wakeup_flags,
  input wire logic direct_xfer_flag,
  input wire logic conv_end_flag,
  input wire logic serial_two_flag,
  input wire logic timer_g_flag,
  input wire logic timer_f_high_flag,
  input wire logic timer_f_low_flag,
  input wire logic timer_c_flag,
  input wire logic timer_b_flag,
  // processor side
  input wire logic global_mask,
  output logic [7:0] pend_one,
  output logic [7:0] pend_two,
  output logic irq_accept_req
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0] edge_sel_r;
    logic [7:0] en_one_r;
    logic [7:0] en_two_r;
    logic [7:0] req_one_r;
    logic [7:0] rdata_r;
    logic [7:0] pend_one_r;
    logic [7:0] pend_two_r;
    logic accept_r;
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  logic [EXT_PINS-1:0] pin_edge;
  logic [7:0] set_one;
  logic [7:0] src_two;
  logic [7:0] pend_one_c;
  logic [7:0] pend_two_c;

  // ****************************************************************
  // edge sensing
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < EXT_PINS; gi++)
    begin : g_edge
      pin_edge_detect u_edge
      (
        .clk(clk),
        .rst_n(rst_n),
        .pin(ext_pin[gi]),
        .rising_sel(st_r.edge_sel_r[gi]),
        .edge_seen(pin_edge[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    set_one = 8'h00;
    set_one[BIT_TIMER_A] = timer_a_overflow;
    set_one[BIT_SERIAL_ONE] = serial_one_done;
    set_one[EXT_PINS-1:0] = pin_edge & ext_pin_is_irq;
    src_two = {direct_xfer_flag, conv_end_flag, serial_two_flag, timer_g_flag,
               timer_f_high_flag, timer_f_low_flag, timer_c_flag, timer_b_flag};
    pend_one_c = 8'h00;
    pend_one_c[BIT_TIMER_A] = st_r.req_one_r[BIT_TIMER_A] & st_r.en_one_r[BIT_TIMER_A];
    pend_one_c[BIT_SERIAL_ONE] = st_r.req_one_r[BIT_SERIAL_ONE]
                                 & st_r.en_one_r[BIT_SERIAL_ONE];
    pend_one_c[BIT_WAKEUP] = (|wakeup_flags) & st_r.en_one_r[BIT_WAKEUP];
    pend_one_c[EXT_PINS-1:0] = st_r.req_one_r[EXT_PINS-1:0]
                               & st_r.en_one_r[EXT_PINS-1:0];
    // one gate per source group of enable two
    pend_two_c = src_two & st_r.en_two_r;

    st_nxt = st_r;
    st_nxt.rdata_r = 8'h00;
    if (wr_stb)
    begin
      case (addr)
        ADDR_EDGE_SEL: st_nxt.edge_sel_r = wdata | EDGE_SEL_FIXED;
        ADDR_EN_ONE: st_nxt.en_one_r = wdata;
        ADDR_EN_TWO: st_nxt.en_two_r = wdata;
        // only zeros clear; ones leave the flag alone
        ADDR_REQ_ONE: st_nxt.req_one_r = st_r.req_one_r & wdata;
        default: st_nxt = st_nxt;
      endcase
    end
    // set after clear so a colliding event survives; acceptance never clears
    st_nxt.req_one_r = st_nxt.req_one_r | set_one | REQ_ONE_FIXED;
    if (rd_stb)
    begin
      case (addr)
        ADDR_EDGE_SEL: st_nxt.rdata_r = st_r.edge_sel_r;
        ADDR_EN_ONE: st_nxt.rdata_r = st_r.en_one_r;
        ADDR_EN_TWO: st_nxt.rdata_r = st_r.en_two_r;
        ADDR_REQ_ONE: st_nxt.rdata_r = st_r.req_one_r;
        ADDR_PENDING: st_nxt.rdata_r = pend_one_c | pend_two_c;
        default: st_nxt.rdata_r = 8'h00;
      endcase
    end
    st_nxt.pend_one_r = pend_one_c;
    st_nxt.pend_two_r = pend_two_c;
    // flags keep setting under the mask; only acceptance is held off
    st_nxt.accept_r = ~global_mask & (|pend_one_c | |pend_two_c);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r.edge_sel_r <= EDGE_SEL_RESET;
      st_r.en_one_r <= EN_RESET;
      st_r.en_two_r <= EN_RESET;
      st_r.req_one_r <= REQ_ONE_RESET;
      st_r.rdata_r <= 8'h00;
      st_r.pend_one_r <= 8'h00;
      st_r.pend_two_r <= 8'h00;
      st_r.accept_r <= 1'b0;
    end
    else
      st_r <= st_nxt;
  end

  assign rdata = st_r.rdata_r;
  assign pend_one = st_r.pend_one_r;
  assign pend_two = st_r.pend_two_r;
  assign irq_accept_req = st_r.accept_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  reserved_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.edge_sel_r[7:5] == 3'b111) else $error("edge select reserved bits not one");
  reserved_req_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.req_one_r[BIT_WAKEUP]) else $error("request reserved bit not one");
  set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
    timer_a_overflow |=> st_r.req_one_r[BIT_TIMER_A]) else $error("timer a event lost");
  serial_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    serial_one_done |=> st_r.req_one_r[BIT_SERIAL_ONE]) else $error("serial one event lost");
  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.req_one_r[0] && !(wr_stb && addr == ADDR_REQ_ONE && !wdata[0]))
    |=> st_r.req_one_r[0]) else $error("flag cleared without write of zero");
  write_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_stb && addr == ADDR_REQ_ONE && wdata[1] && !st_r.req_one_r[1] && !set_one[1])
    |=> !st_r.req_one_r[1]) else $error("write of one changed flag");
  pend_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    st_r.pend_one_r[BIT_TIMER_A] |-> $past(st_r.en_one_r[BIT_TIMER_A]))
    else $error("pending without enable");
  en_two_a: assert property (@(posedge clk) disable iff (!rst_n)
    (timer_b_flag && st_r.en_two_r[BIT_TIMER_B]) |=> pend_two[BIT_TIMER_B])
    else $error("timer b not passed");
  mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    global_mask |=> !irq_accept_req) else $error("accepted under mask");
  en_reset_a: assert property (@(posedge clk)
    $rose(rst_n) |-> st_r.en_one_r == 8'h00) else $error("enable one not reset");
  pin_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_edge[0] && ext_pin_is_irq[0]) |=> st_r.req_one_r[0]) else $error("pin edge lost");
  two_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (st_r.pend_two_r & ~$past(st_r.en_two_r)) == 8'h00) else $error("enable two bypassed");
  accept_src_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq_accept_req |-> (|pend_one || |pend_two)) else $error("accept without pending");
endmodule : irq_enable_flag_control
`default_nettype wire

/* File: tb/cpu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// processor core: mask bit and acceptance
// ****************************************
module cpu_core_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench and block side
  input wire logic mask_req,
  input wire logic irq_accept_req,
  output logic global_mask,
  output logic [7:0] taken_cnt
);
  // masked out of reset so nothing is taken before software is ready
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      global_mask <= 1'b1;
      taken_cnt <= 8'h00;
    end
    else
    begin
      global_mask <= mask_req;
      // acceptance only counts; flags are left for software to clear
      if (irq_accept_req)
        taken_cnt <= taken_cnt + 8'h01;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

/* File: tb/irq_enable_flag_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s exp=%h got=%h", nm, e, g); end end
module irq_enable_flag_control_tb_top;
  import irq_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata, pend_one, pend_two, taken_cnt, e, v;
  logic [7:0] wk = 8'h00;
  logic [7:0] two = 8'h00;
  logic [4:0] pin = 5'h1F;
  logic [4:0] pin_irq = 5'h1F;
  logic ta = 1'b0;
  logic s1 = 1'b0;
  logic mask_req = 1'b0;
  logic global_mask, acc;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int n_tests = 0;
  always #12.5 clk = ~clk;
  irq_enable_flag_control DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .ext_pin(pin), .ext_pin_is_irq(pin_irq),
    .timer_a_overflow(ta), .serial_one_done(s1), .wakeup_flags(wk), .direct_xfer_flag(two[7]),
    .conv_end_flag(two[6]), .serial_two_flag(two[5]), .timer_g_flag(two[4]),
    .timer_f_high_flag(two[3]), .timer_f_low_flag(two[2]), .timer_c_flag(two[1]),
    .timer_b_flag(two[0]), .global_mask(global_mask), .pend_one(pend_one),
    .pend_two(pend_two), .irq_accept_req(acc));
  cpu_core_model core (.clk(clk), .rst_n(rst_n), .mask_req(mask_req),
    .irq_accept_req(acc), .global_mask(global_mask), .taken_cnt(taken_cnt));
  // ****************************************
  // bus tasks and read monitor
  // ****************************************
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(d);
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask : rd
  // ends on a falling edge so port checks never race the register updates
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : tick
  task automatic finish_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  always @(posedge clk) rd_d <= rd_stb;
  always @(negedge clk)
  begin
    if (rd_d)
    begin
      e = exp_q.pop_front();
      `CHK("rdata", e, rdata)
    end
  end
  initial
  begin
    #(25 * 6000);
    error_cnt++;
    finish_test();
  end
  initial
  begin
    void'($urandom(90));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_EDGE_SEL, 8'hE0);
    rd(ADDR_EN_ONE, 8'h00);
    rd(ADDR_EN_TWO, 8'h00);
    rd(ADDR_REQ_ONE, 8'h20);
    rd(4'hF, 8'h00);
    wr(ADDR_EDGE_SEL, 8'h00);
    rd(ADDR_EDGE_SEL, 8'hE0);
    wr(ADDR_REQ_ONE, 8'hFF);
    rd(ADDR_REQ_ONE, 8'h20);
    v = 8'($urandom);
    wr(ADDR_EN_ONE, v);
    rd(ADDR_EN_ONE, v);
    for (int i = 0; i < 16; i++)
    begin
      v = (i < 8) ? (8'h01 << i) : 8'($urandom);
      e = 8'($urandom) | ((i < 8) ? v : 8'h00);
      two <= e;
      wr(ADDR_EN_TWO, v);
      tick(3);
      `CHK("pend_two", e & v, pend_two)
    end
    two <= 8'h00;
    wr(ADDR_EN_ONE, 8'h80);
    ta <= 1'b1;
    @(posedge clk);
    ta <= 1'b0;
    tick(4);
    `CHK("pend_one", 8'h80, pend_one)
    rd(ADDR_PENDING, 8'h80);
    `CHK("accept", 1'b1, acc)
    `CHK("taken", 1'b1, taken_cnt != 8'h00)
    rd(ADDR_REQ_ONE, 8'hA0);
    mask_req <= 1'b1;
    tick(3);
    `CHK("accept", 1'b0, acc)
    wr(ADDR_REQ_ONE, 8'hFF);
    rd(ADDR_REQ_ONE, 8'hA0);
    wr(ADDR_REQ_ONE, 8'h7F);
    rd(ADDR_REQ_ONE, 8'h20);
    // clear and set land on the same edge
    @(posedge clk);
    addr <= ADDR_REQ_ONE;
    wdata <= 8'h00;
    wr_stb <= 1'b1;
    s1 <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    s1 <= 1'b0;
    rd(ADDR_REQ_ONE, 8'h60);
    wr(ADDR_EN_ONE, 8'h40);
    tick(3);
    `CHK("pend_one", 8'h40, pend_one)
    wr(ADDR_REQ_ONE, 8'h00);
    wr(ADDR_EN_ONE, 8'h20);
    wk <= 8'h01 << ($urandom % 8);
    tick(3);
    `CHK("pend_one", 8'h20, pend_one)
    wr(ADDR_EN_ONE, 8'h1F);
    for (int n = 0; n < 5; n++)
    begin
      pin[n] <= 1'b0;
      tick(2);
      `CHK("pend_one", 8'h01 << n, pend_one)
      rd(ADDR_REQ_ONE, 8'h20 | (8'h01 << n));
      wr(ADDR_REQ_ONE, 8'h00);
      wr(ADDR_EDGE_SEL, 8'h1F);
      pin[n] <= 1'b1;
      tick(2);
      rd(ADDR_REQ_ONE, 8'h20 | (8'h01 << n));
      wr(ADDR_REQ_ONE, 8'h00);
      wr(ADDR_EDGE_SEL, 8'h00);
    end
    pin_irq <= 5'h1E;
    pin[0] <= 1'b0;
    tick(2);
    rd(ADDR_REQ_ONE, 8'h20);
    tick(2);
    finish_test();
  end
endmodule : irq_enable_flag_control_tb_top
`default_nettype wire
